// [design/ddr_controller_end.sv]
`timescale 1ns/1ns
`default_nettype none
module ddr_controller_end (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Link to memory
	ddr_link_if.controller link
);
	// ----------------------------------------
	// Register map: 0x0 command, 0x4 read data, 0x8 status
	// ----------------------------------------
	// Command word: [3:0] cmd, [6:4] bank, [21:7] address
	logic [3:0] cmd_ff;
	logic [3:0] pend_ff;
	logic launched_ff;
	logic [2:0] ba_ff;
	logic [14:0] ad_ff;
	logic busy_ff, ck_ff;
	logic [1:0] div_ff;
	logic [31:0] capture_ff;
	logic [2:0] capCnt_ff;
	logic [1:0] oeSync_ff, dqSync_ff;
	logic [1:0] stbSync_ff;
	logic stbPrev_ff;
	logic [31:0] prdata_ff;
	logic pready_ff, pslverr_ff;

	wire access = psel && penable && !pready_ff;
	// Write lands only at the edge where the master sees pready high
	wire done = psel && penable && pready_ff;
	wire wrCmd = done && pwrite && paddr == ddr_readout_pkg::OFF_CMD && !busy_ff;
	wire known = paddr == ddr_readout_pkg::OFF_CMD || paddr == ddr_readout_pkg::OFF_DATA ||
		paddr == ddr_readout_pkg::OFF_STAT;
	wire [31:0] rdMux = paddr == ddr_readout_pkg::OFF_DATA ? capture_ff :
		paddr == ddr_readout_pkg::OFF_STAT ? {31'h0, busy_ff} : {10'h0, ad_ff, ba_ff, pend_ff};

	// APB answer one cycle into access; unmapped gets error
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0;
		end else begin
			pready_ff <= access;
			pslverr_ff <= access && !known;
			prdata_ff <= access && !pwrite ? rdMux : 32'h0;
		end
	end

	// Link clock by divider; command held for one ck period
	wire ckFall = ck_ff && div_ff == 2'h3;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			div_ff <= 2'h0;
			ck_ff <= 1'b0;
			busy_ff <= 1'b0;
			cmd_ff <= ddr_readout_pkg::CMD_NOP;
			pend_ff <= ddr_readout_pkg::CMD_NOP;
			launched_ff <= 1'b0;
			ba_ff <= 3'h0;
			ad_ff <= 15'h0;
		end else begin
			div_ff <= div_ff + 2'h1;
			if (div_ff == 2'h3)
				ck_ff <= ~ck_ff;
			// R5 R6 R16 R18 R20 software orders commands
			// Launch and retire only at ck falls, so a command always brackets one rise
			if (wrCmd) begin
				pend_ff <= pwdata[3:0];
				ba_ff <= pwdata[6:4];
				ad_ff <= pwdata[21:7];
				busy_ff <= 1'b1;
				launched_ff <= 1'b0;
			end else if (ckFall && busy_ff && !launched_ff) begin
				cmd_ff <= pend_ff;
				launched_ff <= 1'b1;
			end else if (ckFall && busy_ff) begin
				cmd_ff <= ddr_readout_pkg::CMD_NOP;
				busy_ff <= 1'b0;
				launched_ff <= 1'b0;
			end
		end
	end

	// Capture returned beats, bit 0 of each
	wire stbEdge = stbSync_ff[1] ^ stbPrev_ff;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			oeSync_ff <= 2'h0;
			dqSync_ff <= 2'h0;
			stbSync_ff <= 2'h0;
			stbPrev_ff <= 1'b0;
			capture_ff <= 32'h0;
			capCnt_ff <= 3'h0;
		end else begin
			oeSync_ff <= {oeSync_ff[0], link.dqOe};
			dqSync_ff <= {dqSync_ff[0], link.dqOut[0]};
			stbSync_ff <= {stbSync_ff[0], link.dqStrobe};
			stbPrev_ff <= stbSync_ff[1];
			// Count restarts between bursts, so beat 0 always lands in bit 0
			if (stbEdge && oeSync_ff[1]) begin
				capture_ff[capCnt_ff] <= dqSync_ff[1];
				capCnt_ff <= capCnt_ff + 3'h1;
			end else if (!oeSync_ff[1]) begin
				capCnt_ff <= 3'h0;
			end
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign link.ck = ck_ff;
	assign link.csN = cmd_ff[3];
	assign link.rasN = cmd_ff[2];
	assign link.casN = cmd_ff[1];
	assign link.weN = cmd_ff[0];
	assign link.ba = ba_ff;
	assign link.addr = ad_ff;
endmodule : ddr_controller_end
`default_nettype wire

// [design/ddr_memory_end.sv]
// What this block does
// R1 - Readout off: reads come from array
// R2 - Readout on: reads return selected source
// R3 - Readout is one bit over all pins
// R4 - Pin 0 carries bit, others copy
// R5 - Controller drives low column bits 00
// R6 - Bit 2 picks chopped nibble order
// R7 - Bank and other column bits ignored
// R8 - Bit 12 chops when on-the-fly enabled
// R9 - Readout uses ordinary read latency
// R10 - Readout only after delay loop locked; no lock is modelled here, so readout works from reset
// R11 - Beat 0 is LSB, beat 7 MSB
// R12 - Code 00 returns alternating 0,1 pattern
// R13 - Reserved select codes give undefined data
// R14 - ACTIVE opens row in selected bank
// R15 - Row stays open until PRECHARGE
// R16 - Close row before activating another
// R17 - PRECHARGE closes one or all banks
// R18 - Wait precharge time before activating
// R19 - Other-bank access during auto close allowed
// R20 - Idle bank needs ACTIVE before read
// R21 - PRECHARGE accepted on idle bank
// R22 - Bit 12 low chops, high full burst
`timescale 1ns/1ns
`default_nettype none
module ddr_memory_end (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Link to controller
	ddr_link_if.memory link,
	// Status toward user
	output logic readoutMode,
	output logic [ddr_readout_pkg::NUM_BANKS-1:0] bankOpen,
	output logic [ddr_readout_pkg::ROW_BITS-1:0] lastRow
);
	// ----------------------------------------
	// Link input synchronisers
	// ----------------------------------------
	logic [1:0] ckSync_ff;
	logic ckPrev_ff;
	logic [3:0] cmdMeta_ff, cmdSync_ff;
	logic [2:0] baMeta_ff, baSync_ff;
	logic [14:0] adMeta_ff, adSync_ff;

	// Two stages on every pin; command pins stable across ck rises
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ckSync_ff <= 2'h0;
			ckPrev_ff <= 1'b0;
			cmdMeta_ff <= ddr_readout_pkg::CMD_NOP;
			cmdSync_ff <= ddr_readout_pkg::CMD_NOP;
			baMeta_ff <= 3'h0;
			baSync_ff <= 3'h0;
			adMeta_ff <= 15'h0;
			adSync_ff <= 15'h0;
		end else begin
			ckSync_ff <= {ckSync_ff[0], link.ck};
			ckPrev_ff <= ckSync_ff[1];
			cmdMeta_ff <= {link.csN, link.rasN, link.casN, link.weN};
			cmdSync_ff <= cmdMeta_ff;
			baMeta_ff <= link.ba;
			baSync_ff <= baMeta_ff;
			adMeta_ff <= link.addr;
			adSync_ff <= adMeta_ff;
		end
	end

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	wire ckRise = ckSync_ff[1] & ~ckPrev_ff;
	wire isActive = ckRise && cmdSync_ff == ddr_readout_pkg::CMD_ACTIVE;
	wire isRead = ckRise && cmdSync_ff == ddr_readout_pkg::CMD_READ;
	wire isPre = ckRise && cmdSync_ff == ddr_readout_pkg::CMD_PRECHARGE;
	wire isMrs = ckRise && cmdSync_ff == ddr_readout_pkg::CMD_MODE_SET;
	wire preAll = adSync_ff[ddr_readout_pkg::AUTO_CLOSE_BIT];

	// ----------------------------------------
	// Mode registers
	// ----------------------------------------
	logic [1:0] burstMode_ff;
	logic [2:0] readoutReg_ff;
	wire readoutOn = readoutReg_ff[ddr_readout_pkg::READOUT_ENABLE_BIT];

	// Mode set stores burst field or readout field
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			burstMode_ff <= ddr_readout_pkg::RESET_BURST_MODE;
			readoutReg_ff <= ddr_readout_pkg::RESET_READOUT_MODE;
		end else if (isMrs) begin
			if (baSync_ff == ddr_readout_pkg::MODE_REG_BURST)
				burstMode_ff <= adSync_ff[1:0];
			// R2 enable readout
			if (baSync_ff == ddr_readout_pkg::MODE_REG_THREE)
				readoutReg_ff <= adSync_ff[2:0];
		end
	end

	// ----------------------------------------
	// Bank rows
	// ----------------------------------------
	logic [ddr_readout_pkg::NUM_BANKS-1:0] open_ff;
	logic [14:0] row_ff;

	// Per-bank open flag; precharge on idle bank harmless
	genvar b;
	generate
		for (b = 0; b < ddr_readout_pkg::NUM_BANKS; b++) begin : gBank
			wire hitBank = baSync_ff == 3'(b);
			always_ff @(posedge sys_clk or negedge reset_n) begin
				if (!reset_n)
					open_ff[b] <= 1'b0;
				// R17 R21 close one or all
				else if (isPre && (preAll || hitBank))
					open_ff[b] <= 1'b0;
				// R14 R15 open row
				else if (isActive && hitBank)
					open_ff[b] <= 1'b1;
			end
		end
	endgenerate

	// R14 row capture
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			row_ff <= 15'h0;
		else if (isActive)
			row_ff <= adSync_ff;
	end

	// ----------------------------------------
	// Read burst engine
	// ----------------------------------------
	// R22 R8 chop choice from mode or bit 12
	wire chopNow = (burstMode_ff == ddr_readout_pkg::BURST_FIXED_CHOP) ||
		(burstMode_ff == ddr_readout_pkg::BURST_ON_THE_FLY &&
		!adSync_ff[ddr_readout_pkg::CHOP_SELECT_BIT]);
	// R6 R7 only bit 2 picks start beat; others ignored
	wire [2:0] startBeat = {adSync_ff[ddr_readout_pkg::NIBBLE_SELECT_BIT] & chopNow, 2'h0};
	// R12 R13 pattern for 00, zero for reserved codes
	wire [7:0] readoutSrc = (readoutReg_ff[1:0] == ddr_readout_pkg::READOUT_SEL_PATTERN)
		? ddr_readout_pkg::CAL_PATTERN : 8'h00;

	typedef enum logic [1:0] {IDLE, WAIT, BURST} burst_t;
	burst_t st_ff;
	logic [2:0] lat_ff, beat_ff, left_ff;
	logic useReadout_ff;
	logic [7:0] src_ff;
	logic [7:0] dqOut_ff;
	logic dqOe_ff, strobe_ff;

	// R1 array reads return fill data
	wire [7:0] sourceByte = readoutOn ? readoutSrc : ddr_readout_pkg::ARRAY_DATA_FILL;
	// R11 beat index picks bit
	wire beatBit = src_ff[beat_ff];
	// R3 R4 bit repeated on every pin
	wire [7:0] beatByte = useReadout_ff ? {8{beatBit}} : ddr_readout_pkg::ARRAY_DATA_FILL;

	// One beat per link clock rise after latency
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_ff <= IDLE;
			lat_ff <= 3'h0;
			beat_ff <= 3'h0;
			left_ff <= 3'h0;
			useReadout_ff <= 1'b0;
			src_ff <= 8'h00;
			dqOut_ff <= 8'h00;
			dqOe_ff <= 1'b0;
			strobe_ff <= 1'b0;
		end else begin
			unique case (st_ff)
				IDLE: begin
					dqOe_ff <= 1'b0;
					strobe_ff <= 1'b0;
					if (isRead) begin
						st_ff <= WAIT;
						// R9 same latency as array read
						lat_ff <= ddr_readout_pkg::READ_LATENCY;
						beat_ff <= startBeat;
						left_ff <= chopNow ? 3'h3 : 3'h7;
						useReadout_ff <= readoutOn;
						src_ff <= sourceByte;
					end
				end
				WAIT: begin
					if (ckRise) begin
						lat_ff <= lat_ff - 3'h1;
						if (lat_ff == 3'h1)
							st_ff <= BURST;
					end
				end
				BURST: begin
					if (ckRise) begin
						dqOut_ff <= beatByte;
						dqOe_ff <= 1'b1;
						strobe_ff <= ~strobe_ff;
						beat_ff <= beat_ff + 3'h1;
						left_ff <= left_ff - 3'h1;
						if (left_ff == 3'h0)
							st_ff <= IDLE;
					end
				end
			endcase
		end
	end

	assign link.dqOut = dqOut_ff;
	assign link.dqOe = dqOe_ff;
	assign link.dqStrobe = strobe_ff;
	assign readoutMode = readoutReg_ff[ddr_readout_pkg::READOUT_ENABLE_BIT];
	assign bankOpen = open_ff;
	assign lastRow = row_ff;
endmodule : ddr_memory_end
`default_nettype wire

// [pkg/ddr_link_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface ddr_link_if;
	logic ck;
	logic csN;
	logic rasN;
	logic casN;
	logic weN;
	logic [ddr_readout_pkg::BANK_BITS-1:0] ba;
	logic [ddr_readout_pkg::ROW_BITS-1:0] addr;
	logic [ddr_readout_pkg::DQ_BITS-1:0] dqOut;
	logic dqOe;
	logic dqStrobe;

	modport memory (input ck, csN, rasN, casN, weN, ba, addr,
		output dqOut, dqOe, dqStrobe);
	modport controller (output ck, csN, rasN, casN, weN, ba, addr,
		input dqOut, dqOe, dqStrobe);
endinterface : ddr_link_if
`default_nettype wire

// [pkg/ddr_readout_pkg.sv]
package ddr_readout_pkg;
	// ----------------------------------------
	// Command encodings {csN, rasN, casN, weN}
	// ----------------------------------------
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_ACTIVE = 4'h3;
	localparam logic [3:0] CMD_READ = 4'h5;
	localparam logic [3:0] CMD_PRECHARGE = 4'h2;
	localparam logic [3:0] CMD_MODE_SET = 4'h0;

	// ----------------------------------------
	// Address field positions
	// ----------------------------------------
	localparam int ROW_BITS = 15;
	localparam int BANK_BITS = 3;
	localparam int NUM_BANKS = 8;
	localparam int DQ_BITS = 8;
	localparam int READOUT_ENABLE_BIT = 2;
	localparam int CHOP_SELECT_BIT = 12;
	localparam int AUTO_CLOSE_BIT = 10;
	localparam int NIBBLE_SELECT_BIT = 2;
	localparam int MR_BURST_FIELD_LO = 0;
	localparam logic [2:0] MODE_REG_BURST = 3'h0;
	localparam logic [2:0] MODE_REG_THREE = 3'h3;
	localparam logic [1:0] BURST_FIXED_EIGHT = 2'h0;
	localparam logic [1:0] BURST_ON_THE_FLY = 2'h1;
	localparam logic [1:0] BURST_FIXED_CHOP = 2'h2;
	localparam logic [1:0] READOUT_SEL_PATTERN = 2'h0;

	// ----------------------------------------
	// Controller register offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_DATA = 8'h04;
	localparam logic [7:0] OFF_STAT = 8'h08;

	// ----------------------------------------
	// Pattern, reset values and timing
	// ----------------------------------------
	localparam logic [7:0] CAL_PATTERN = 8'haa;
	localparam logic [7:0] ARRAY_DATA_FILL = 8'h00;
	localparam logic [2:0] READ_LATENCY = 3'h5;
	localparam int SYS_CLK_NS = 40;
	localparam int LINK_DIV_HALF = 4;
	localparam int ROW_PRECHARGE_TIME_NS = 15;
	localparam int ROW_PRECHARGE_LINK_CYCLES = 1;
	localparam logic [1:0] RESET_BURST_MODE = 2'h0;
	localparam logic [2:0] RESET_READOUT_MODE = 3'h0;
endpackage : ddr_readout_pkg

// [testbench/ddr3_readout_and_bank_rows_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module ddr3_readout_and_bank_rows_bench;
	logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, errBit;
	logic readoutMode, stbPrev;
	logic [7:0] paddr, bankOpen, capBits;
	logic [31:0] pwdata, prdata, rdata;
	logic [14:0] lastRow;
	int n_fail, n_checks, capN;
	ddr_link_if link();
	ddr_controller_end ddr_controller_end_i (.sys_clk(sys_clk), .reset_n(reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
	ddr_memory_end ddr_memory_end_i (.sys_clk(sys_clk), .reset_n(reset_n), .link(link),
		.readoutMode(readoutMode), .bankOpen(bankOpen), .lastRow(lastRow));
	ddr_link_props ddr_link_props_i (.sys_clk(sys_clk), .reset_n(reset_n), .ck(link.ck),
		.csN(link.csN), .rasN(link.rasN), .casN(link.casN), .weN(link.weN), .ba(link.ba),
		.addr(link.addr), .dqOut(link.dqOut), .dqOe(link.dqOe), .dqStrobe(link.dqStrobe));
	// ------
	// Clock, monitor, tasks
	// ------
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// Pin 0 is taken at each strobe toggle inside a burst
	always @(posedge sys_clk) begin
		if (link.dqOe === 1'b1 && link.dqStrobe !== stbPrev) begin
			capBits[capN[2:0]] = link.dqOut[0];
			capN++;
		end
		stbPrev = link.dqStrobe;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rdata = prdata;
		errBit = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb
	task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a);
		apb(1'b1, 8'h00, {10'h000, a, b, c});
		do apb(1'b0, 8'h08, 32'h0); while (rdata[0] !== 1'b0);
		// Far end acts only after its input synchronisers
		repeat (16) @(posedge sys_clk);
	endtask : cmd
	task automatic mrs(input logic [2:0] b, input logic [14:0] a);
		cmd(ddr_readout_pkg::CMD_MODE_SET, b, a);
	endtask : mrs
	task automatic rd(input logic [14:0] a, input int n, input logic [7:0] bits);
		capN = 0;
		capBits = 8'h00;
		// callers keep column bits 00; delay loop taken as locked from reset
		cmd(ddr_readout_pkg::CMD_READ, 3'h7, a);
		for (int i = 0; i < 300 && (capN == 0 || link.dqOe === 1'b1); i++) @(posedge sys_clk);
		chk(capN, n);
		chk(capBits, bits);
	endtask : rd
	// ------
	// Scenarios
	// ------
	task automatic t_rows();
		cmd(ddr_readout_pkg::CMD_ACTIVE, 3'h5, 15'h1234);
		chk({bankOpen, 9'h0, lastRow}, {8'h20, 9'h0, 15'h1234});
		cmd(ddr_readout_pkg::CMD_ACTIVE, 3'h2, 15'h7fff);
		chk({bankOpen, 9'h0, lastRow}, {8'h24, 9'h0, 15'h7fff});
		// close before reuse; command spacing exceeds precharge time
		cmd(ddr_readout_pkg::CMD_PRECHARGE, 3'h5, 15'h0000);
		chk(bankOpen, 8'h04);
		cmd(ddr_readout_pkg::CMD_PRECHARGE, 3'h5, 15'h0000);
		chk(bankOpen, 8'h04);
		cmd(ddr_readout_pkg::CMD_PRECHARGE, 3'h0, 15'h0400);
		chk(bankOpen, 8'h00);
		$display("test rows done");
	endtask : t_rows
	task automatic t_readout();
		mrs(3'h3, 15'h0004);
		chk(readoutMode, 1'b1);
		mrs(3'h0, 15'h0001);
		// auto close bit clear; bit 12 set, so the on-the-fly read is a full burst
		rd(15'h3bf8, 8, 8'haa);
		apb(1'b0, 8'h04, 32'h0);
		chk(rdata[7:0], 8'haa);
		rd(15'h0000, 4, 8'h0a);
		rd(15'h0004, 4, 8'h0a);
		mrs(3'h0, 15'h0002);
		rd(15'h1000, 4, 8'h0a);
		mrs(3'h0, 15'h0000);
		rd(15'h0000, 8, 8'haa);
		$display("test readout done");
	endtask : t_readout
	task automatic t_normal();
		// reserved select codes only written with readout off
		mrs(3'h3, 15'h0003);
		chk(readoutMode, 1'b0);
		// row opened before the array read
		cmd(ddr_readout_pkg::CMD_ACTIVE, 3'h7, 15'h0001);
		rd(15'h1000, 8, 8'h00);
		apb(1'b0, 8'h04, 32'h0);
		chk(rdata[7:0], 8'h00);
		cmd(ddr_readout_pkg::CMD_PRECHARGE, 3'h7, 15'h0000);
		apb(1'b0, 8'h0c, 32'h0);
		chk(errBit, 1'b1);
		$display("test normal done");
	endtask : t_normal
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_fail = 0;
		n_checks = 0;
		capN = 0;
		stbPrev = 1'b0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		t_rows();
		t_readout();
		t_normal();
		tally_and_finish();
	end
	// Whole run needs under two thousand cycles; this bound cuts a hang
	initial begin
		repeat (30000) @(posedge sys_clk);
		n_fail++;
		$display("[FAIL] %0t watchdog expired", $time);
		tally_and_finish();
	end
endmodule : ddr3_readout_and_bank_rows_bench
`default_nettype wire

// [testbench/ddr_link_props.sv]
`timescale 1ns/1ns
`default_nettype none
module ddr_link_props (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Link pins
	input wire logic ck,
	input wire logic csN,
	input wire logic rasN,
	input wire logic casN,
	input wire logic weN,
	input wire logic [2:0] ba,
	input wire logic [14:0] addr,
	input wire logic [7:0] dqOut,
	input wire logic dqOe,
	input wire logic dqStrobe
);
	// ------
	// Trackers
	// ------
	logic ckD_ff, stbD_ff, rdOn_ff, chop_ff;
	logic [1:0] sel_ff, burst_ff;
	logic [3:0] beats_ff;
	// Commands count only at a link clock rise, as the far end sees them
	wire [3:0] cmd = {csN, rasN, casN, weN};
	wire ckRise = ck & ~ckD_ff;
	wire mrsEdge = ckRise && cmd == ddr_readout_pkg::CMD_MODE_SET;
	wire readEdge = ckRise && cmd == ddr_readout_pkg::CMD_READ;
	wire beat = dqOe && dqStrobe != stbD_ff;
	wire chopNow = burst_ff == ddr_readout_pkg::BURST_FIXED_CHOP ||
		(burst_ff == ddr_readout_pkg::BURST_ON_THE_FLY && !addr[12]);
	// Mirror of mode settings; beat count clears between bursts
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ckD_ff <= 1'b0;
			stbD_ff <= 1'b0;
			rdOn_ff <= 1'b0;
			chop_ff <= 1'b0;
			sel_ff <= 2'h0;
			burst_ff <= 2'h0;
			beats_ff <= 4'h0;
		end else begin
			ckD_ff <= ck;
			stbD_ff <= dqStrobe;
			rdOn_ff <= (mrsEdge && ba == 3'h3) ? addr[2] : rdOn_ff;
			sel_ff <= (mrsEdge && ba == 3'h3) ? addr[1:0] : sel_ff;
			burst_ff <= (mrsEdge && ba == 3'h0) ? addr[1:0] : burst_ff;
			chop_ff <= readEdge ? chopNow : chop_ff;
			beats_ff <= dqOe ? beats_ff + 4'(beat) : 4'h0;
		end
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	a_pins_copy: assert property (
		dqOe |-> dqOut[7:1] == {7{dqOut[0]}} || dqOut[7:1] == 7'h00)
		else $error("upper data pins neither copy nor zero");
	a_array_zero: assert property (
		dqOe && !rdOn_ff |-> dqOut == 8'h00)
		else $error("array read data not zero");
	a_pattern_bit: assert property (
		beat && rdOn_ff && sel_ff == 2'h0 |-> dqOut[0] == beats_ff[0])
		else $error("calibration pattern bit wrong");
	a_burst_len: assert property (
		$fell(dqOe) |-> beats_ff == (chop_ff ? 4'h4 : 4'h8))
		else $error("burst beat count wrong");
	a_read_latency: assert property (
		readEdge |-> !dqOe [*8] ##[28:50] $rose(dqOe))
		else $error("read data not at read latency");
	a_strobe_burst: assert property (
		$changed(dqStrobe) |-> dqOe)
		else $error("strobe moved outside a burst");
	a_beat_spacing: assert property (
		beat |=> !beat [*6])
		else $error("beats closer than one link period");
	a_cmd_stands: assert property (
		$changed(cmd) |=> $stable(cmd) [*6])
		else $error("command shorter than one link period");
endmodule : ddr_link_props
`default_nettype wire
